// ==== verilog/sltx_pkg.sv ====
package sltx_pkg;

	// ----------------------------------------------------------------
	// register selects and field positions
	// ----------------------------------------------------------------
	localparam logic [0:0] REG_TX_CONTROL_STATUS  = 1'h0;
	localparam logic [0:0] REG_TX_HOLDING_BUFFER  = 1'h1;
	localparam int         BIT_TX_READY           = 7;
	localparam int         BIT_TX_IRQ_ENABLE      = 6;
	localparam int         BIT_LOOPBACK_TEST      = 2;
	localparam int         BIT_BREAK_CONTROL      = 0;
	localparam int         BIT_MODEM_IRQ_ENABLE   = 5;

	// ----------------------------------------------------------------
	// reset values and defaults
	// ----------------------------------------------------------------
	localparam logic [2:0] DEF_PRIORITY_LEVEL     = 3'h4;
	localparam logic [8:0] DEF_CONSOLE_VECTOR     = 9'h030;
	localparam logic [8:0] DEF_FLOATING_VECTOR    = 9'h0c0;
	localparam int         MODEM_INPUT_COUNT      = 4;

	// idle: drain one holding char; shift: a char is on the line
	typedef enum logic [1:0] {
		SLTX_IDLE  = 2'b00,
		SLTX_SHIFT = 2'b01
	} sltx_state_e;

	typedef enum logic [1:0] {
		SLTX_ARB_IDLE  = 2'b00,
		SLTX_ARB_REQ   = 2'b01,
		SLTX_ARB_GRANT = 2'b11
	} sltx_arb_e;

endpackage

// ==== verilog/sltx_ctrl.sv ====
// Behaviour
// - ready flag in control bit 07 shows holding buffer empty and able to accept.
// - ready flag read-only; clear pulse sets it, buffer write clears it.
// - ready flag rising with enable bit 06 starts transmitter interrupt request.
// - interrupt enable, loopback and break bits read/write, cleared by clear pulse.
// - loopback bit 02 feeds receiver from transmitter output, ignoring line input.
// - loopback bit 02 makes receiver run at the transmitter bit rate.
// - break bit 00 holds serial output at continuous space.
// - buffer takes write bits 07-00 as character; bits 15-08 ignored.
// - two independent channels; receiver granted first when both request.
// - receive done rising with receive enable starts a receiver data request.
// - modem change rising with modem enable bit 05 also requests receiver channel.
// - change on carrier, clear to send, secondary receive or ring sets modem flag.
// - receiver data and modem sources share one channel and one vector.
// - both channels request at level 4 by default; level set by plug.
// - jumper vector; console default octal 060, else floating vector.
// - raise request line, take bus on grant, present vector.
// - receive done sets at middle of first stop bit.
// - double buffered; first load frees ready quickly, second holds it a character.
`timescale 1ns/1ps
module sltx_ctrl #(
	parameter logic [2:0] PRIORITY_LEVEL = sltx_pkg::DEF_PRIORITY_LEVEL,
	parameter logic [8:0] VECTOR         = sltx_pkg::DEF_CONSOLE_VECTOR,
	parameter int         DATA_BITS      = 8
) (
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        clk_en_in,
	input  wire logic        bus_init_in,
	input  wire logic        reg_sel_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [15:0] reg_wdata_in,
	output logic      [15:0] reg_rdata_out,
	output logic             shift_load_out,
	output logic      [7:0]  shift_data_out,
	input  wire logic        shift_done_in,
	input  wire logic        shift_serial_in,
	output logic             serial_out,
	input  wire logic        serial_line_in,
	output logic             rx_serial_out,
	input  wire logic        tx_rate_tick_in,
	input  wire logic        rx_rate_tick_in,
	output logic             rx_rate_tick_out,
	output logic             loopback_test_out,
	input  wire logic        rx_char_done_in,
	input  wire logic        rx_irq_enable_in,
	input  wire logic        modem_irq_enable_in,
	input  wire logic        carrier_detect_in,
	input  wire logic        cts_in,
	input  wire logic        secondary_receive_in,
	input  wire logic        ring_in,
	input  wire logic        modem_change_clear_in,
	output logic             modem_change_out,
	output logic             bus_request_line_out,
	output logic      [2:0]  bus_request_level_out,
	input  wire logic        bus_grant_in,
	output logic             bus_vector_valid_out,
	output logic      [8:0]  bus_vector_out,
	output logic             rx_irq_pending_out,
	output logic             tx_irq_pending_out
);
	import sltx_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (DATA_BITS < 5 || DATA_BITS > 8) begin : g_bad_bits
		$error("data bits must lie between 5 and 8");
	end
	if (VECTOR[1:0] != 2'h0) begin : g_bad_vec
		$error("vector must be a multiple of four");
	end
	// the transmitter vector sits four above the base and must not wrap
	if (VECTOR > 9'h1f8) begin : g_vec_wrap
		$error("vector leaves no room for the transmitter vector");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		// control register
		logic        tx_ready;
		logic        tx_irq_enable;
		logic        loopback_test;
		logic        break_ctrl;
		// transmit double buffer: hold stage, then the char on the line
		logic        hold_full;
		logic [7:0]  hold_data;
		sltx_state_e shift_state;
		logic        load;
		logic [7:0]  shift_data;
		// interrupt requests and their edge detectors
		logic        tx_req;
		logic        rx_req;
		logic        rx_done_prev;
		logic        modem_flag;
		logic        modem_prev;
		// pin synchronisers
		logic [MODEM_INPUT_COUNT-1:0] modem_s1;
		logic [MODEM_INPUT_COUNT-1:0] modem_s2;
		logic [MODEM_INPUT_COUNT-1:0] modem_last;
		logic        line_s1;
		logic        line_s2;
		// bus arbiter, vector and read data
		sltx_arb_e   arb;
		logic        grant_rx;
		logic        vec_valid;
		logic [8:0]  vec;
		logic [15:0] rdata;
	} sltx_ctrl_s;

	sltx_ctrl_s st_q;
	sltx_ctrl_s st_d;

	function automatic logic [7:0] right_justify(input logic [15:0] w);
		logic [7:0] m;
		// bits above the configured width are dropped so they never reach the line
		m = 8'hff >> (8 - DATA_BITS);
		return w[7:0] & m;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic wr_csr;
		logic wr_buf;
		logic modem_changed;
		logic modem_rise;
		logic done_rise;
		logic ready_set;
		wr_csr = 1'b0;
		wr_buf = 1'b0;
		modem_changed = 1'b0;
		modem_rise = 1'b0;
		done_rise = 1'b0;
		ready_set = 1'b0;
		st_d = st_q;
		st_d.load = 1'b0;
		st_d.vec_valid = 1'b0;

		// ----------------------------------------------------------------
		// pin synchronisers
		// ----------------------------------------------------------------
		// only the second and third flops are read by logic; the first may be metastable
		st_d.modem_s1 = {ring_in, secondary_receive_in, cts_in, carrier_detect_in};
		st_d.modem_s2 = st_q.modem_s1;
		st_d.modem_last = st_q.modem_s2;
		st_d.line_s1 = serial_line_in;
		st_d.line_s2 = st_q.line_s1;

		// ----------------------------------------------------------------
		// register writes
		// ----------------------------------------------------------------
		// ready is read-only, so bit 07 of a control write is ignored
		wr_csr = reg_wr_in && reg_sel_in == REG_TX_CONTROL_STATUS;
		wr_buf = reg_wr_in && reg_sel_in == REG_TX_HOLDING_BUFFER;

		if (wr_csr) begin
			st_d.tx_irq_enable = reg_wdata_in[BIT_TX_IRQ_ENABLE];
			st_d.loopback_test = reg_wdata_in[BIT_LOOPBACK_TEST];
			st_d.break_ctrl    = reg_wdata_in[BIT_BREAK_CONTROL];
		end

		// ----------------------------------------------------------------
		// transmit double buffer
		// ----------------------------------------------------------------
		// shifter hands back its register when done; holding buffer refills it
		if (st_q.shift_state == SLTX_SHIFT && shift_done_in) begin
			st_d.shift_state = SLTX_IDLE;
		end
		if (st_d.shift_state == SLTX_IDLE && st_q.hold_full) begin
			st_d.shift_state = SLTX_SHIFT;
			st_d.shift_data  = st_q.hold_data;
			st_d.load        = 1'b1;
			st_d.hold_full   = 1'b0;
		end
		// a write while full and the shifter busy overwrites the waiting char, as ready was clear
		if (wr_buf) begin
			st_d.hold_data = right_justify(reg_wdata_in);
			st_d.hold_full = 1'b1;
		end
		st_d.tx_ready = !st_d.hold_full;
		ready_set = st_d.tx_ready && !st_q.tx_ready;

		// ----------------------------------------------------------------
		// transmit request
		// ----------------------------------------------------------------
		// event wins over the arbiter clearing the request
		if (ready_set && st_d.tx_irq_enable) begin
			st_d.tx_req = 1'b1;
		end
		if (!st_d.tx_irq_enable) begin
			st_d.tx_req = 1'b0;
		end

		// ----------------------------------------------------------------
		// modem change
		// ----------------------------------------------------------------
		// set wins over the software clear so no change is lost
		modem_changed = |(st_q.modem_s2 ^ st_q.modem_last);
		if (modem_change_clear_in) begin
			st_d.modem_flag = 1'b0;
		end
		if (modem_changed) begin
			st_d.modem_flag = 1'b1;
		end
		modem_rise = st_d.modem_flag && !st_q.modem_prev;
		st_d.modem_prev = st_d.modem_flag;

		// ----------------------------------------------------------------
		// receive done
		// ----------------------------------------------------------------
		done_rise = rx_char_done_in && !st_q.rx_done_prev;
		st_d.rx_done_prev = rx_char_done_in;

		// ----------------------------------------------------------------
		// request / grant / vector
		// ----------------------------------------------------------------
		unique case (st_q.arb)
			// a level request; it drops if both channels withdraw before grant
			SLTX_ARB_IDLE: begin
				if (st_q.rx_req || st_q.tx_req) begin
					st_d.arb = SLTX_ARB_REQ;
				end
			end
			SLTX_ARB_REQ: begin
				// one grant serves one channel; the other waits for the next round
				if (bus_grant_in) begin
					st_d.arb       = SLTX_ARB_GRANT;
					st_d.grant_rx  = st_q.rx_req;
					st_d.vec_valid = 1'b1;
					st_d.vec       = st_q.rx_req ? VECTOR : VECTOR + 9'h004;
					if (st_q.rx_req) begin
						st_d.rx_req = 1'b0;
					end else begin
						st_d.tx_req = 1'b0;
					end
				end else if (!st_q.rx_req && !st_q.tx_req) begin
					st_d.arb = SLTX_ARB_IDLE;
				end
			end
			// wait for the grant to drop so one grant is never used twice
			SLTX_ARB_GRANT: begin
				if (!bus_grant_in) begin
					st_d.arb = SLTX_ARB_IDLE;
				end
			end
			default: st_d.arb = SLTX_ARB_IDLE;
		endcase

		// ----------------------------------------------------------------
		// receiver request
		// ----------------------------------------------------------------
		// both receiver sources share one request and one vector
		if ((done_rise && rx_irq_enable_in) || (modem_rise && modem_irq_enable_in)) begin
			st_d.rx_req = 1'b1;
		end
		if (!rx_irq_enable_in && !modem_irq_enable_in) begin
			st_d.rx_req = 1'b0;
		end
		if (st_d.tx_ready && !st_q.tx_ready && st_d.tx_irq_enable) begin
			st_d.tx_req = 1'b1;
		end

		// ----------------------------------------------------------------
		// read data
		// ----------------------------------------------------------------
		// the holding buffer is write-only and reads back as zero
		st_d.rdata = 16'h0000;
		if (reg_rd_in && reg_sel_in == REG_TX_CONTROL_STATUS) begin
			st_d.rdata[BIT_TX_READY]      = st_q.tx_ready;
			st_d.rdata[BIT_TX_IRQ_ENABLE] = st_q.tx_irq_enable;
			st_d.rdata[BIT_LOOPBACK_TEST] = st_q.loopback_test;
			st_d.rdata[BIT_BREAK_CONTROL] = st_q.break_ctrl;
		end

		// ----------------------------------------------------------------
		// bus clear
		// ----------------------------------------------------------------
		// the clear pulse overrides the control, buffer, request, modem flag and arbiter state updates above; a vector fetched on a grant that cycle still goes out
		if (bus_init_in) begin
			st_d.tx_ready      = 1'b1;
			st_d.tx_irq_enable = 1'b0;
			st_d.loopback_test = 1'b0;
			st_d.break_ctrl    = 1'b0;
			st_d.hold_full     = 1'b0;
			st_d.shift_state   = SLTX_IDLE;
			st_d.load          = 1'b0;
			st_d.tx_req        = 1'b0;
			st_d.rx_req        = 1'b0;
			st_d.modem_flag    = 1'b0;
			st_d.arb           = SLTX_ARB_IDLE;
		end
	end

	always_ff @(posedge clk_in) begin
		// reset leaves the buffer empty, so ready comes up set
		if (srst_in) begin
			st_q <= '0;
			st_q.tx_ready <= 1'b1;
		end else if (clk_en_in) begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata_out         = st_q.rdata;
	assign shift_load_out        = st_q.load;
	assign shift_data_out        = st_q.shift_data;

	// ----------------------------------------------------------------
	// serial path
	// ----------------------------------------------------------------
	// break forces space even mid character; ready keeps running to time it
	assign serial_out            = shift_serial_in && !st_q.break_ctrl;
	assign rx_serial_out         = st_q.loopback_test ? shift_serial_in : st_q.line_s2;
	assign rx_rate_tick_out      = st_q.loopback_test ? tx_rate_tick_in : rx_rate_tick_in;
	assign loopback_test_out     = st_q.loopback_test;
	assign modem_change_out      = st_q.modem_flag;

	// ----------------------------------------------------------------
	// interrupt bus
	// ----------------------------------------------------------------
	assign bus_request_line_out  = st_q.arb == SLTX_ARB_REQ;
	assign bus_request_level_out = PRIORITY_LEVEL;
	assign bus_vector_valid_out  = st_q.vec_valid;
	assign bus_vector_out        = st_q.vec;
	assign rx_irq_pending_out    = st_q.rx_req;
	assign tx_irq_pending_out    = st_q.tx_req;

endmodule

// ==== tb/sltx_chk_asserts.sv ====
`timescale 1ns/1ps
module sltx_chk #(
	parameter logic [8:0] VECTOR = 9'h030
) (
	input wire logic        clk_in,
	input wire logic        srst_in,
	input wire logic        clk_en_in,
	input wire logic        bus_init_in,
	input wire logic        bus_grant_in,
	input wire logic        reg_sel_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic        shift_serial_in,
	input wire logic        tx_rate_tick_in,
	input wire logic        rx_rate_tick_in,
	input wire logic        rx_rate_tick_out,
	input wire logic        rx_serial_out,
	input wire logic        loopback_test_out,
	input wire logic        bus_request_line_out,
	input wire logic        bus_vector_valid_out,
	input wire logic        rx_irq_pending_out,
	input wire logic        tx_irq_pending_out,
	input wire logic [15:0] reg_rdata_out,
	input wire logic [2:0]  bus_request_level_out,
	input wire logic [8:0]  bus_vector_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	sequence s_buf_load_then_read;
		reg_wr_in && reg_sel_in && clk_en_in ##1 reg_rd_in && !reg_sel_in;
	endsequence
	sequence s_granted;
		$rose(bus_grant_in) && bus_request_line_out;
	endsequence
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_ready_clr; s_buf_load_then_read |=> !reg_rdata_out[7]; endproperty
	property p_unused; (reg_rdata_out & 16'hff3a) == 16'h0; endproperty
	property p_buf_wo; reg_rd_in && reg_sel_in |=> reg_rdata_out == 16'h0; endproperty
	property p_loop_data; loopback_test_out |-> rx_serial_out == shift_serial_in; endproperty
	property p_loop_rate;
		rx_rate_tick_out == (loopback_test_out ? tx_rate_tick_in : rx_rate_tick_in);
	endproperty
	property p_level; bus_request_level_out == 3'h4; endproperty
	property p_init; bus_init_in && clk_en_in |=> !loopback_test_out && !tx_irq_pending_out;
	endproperty
	property p_grant; s_granted |=> bus_vector_valid_out; endproperty
	property p_prio; bus_vector_valid_out && $past(rx_irq_pending_out) |-> bus_vector_out == VECTOR;
	endproperty
	property p_txvec;
		bus_vector_valid_out && !$past(rx_irq_pending_out) |-> bus_vector_out == VECTOR + 9'h004;
	endproperty
	property p_req; $rose(tx_irq_pending_out) |-> ##[1:2] bus_request_line_out; endproperty
	a_ready_clr: assert property (p_ready_clr) else $error("ready stuck");
	a_unused: assert property (p_unused) else $error("unused bit set");
	a_buf_wo: assert property (p_buf_wo) else $error("buffer readable");
	a_loop_data: assert property (p_loop_data) else $error("loop data");
	a_loop_rate: assert property (p_loop_rate) else $error("loop rate");
	a_level: assert property (p_level) else $error("level");
	a_init: assert property (p_init) else $error("clear pulse");
	a_grant: assert property (p_grant) else $error("no vector");
	a_prio: assert property (p_prio) else $error("rx not first");
	a_txvec: assert property (p_txvec) else $error("tx vector");
	a_req: assert property (p_req) else $error("no request");
endmodule
bind sltx_ctrl sltx_chk #(.VECTOR(VECTOR)) u_chk (.*);

// ==== tb/sltx_host.sv ====
`timescale 1ns/1ps
module sltx_host (
	input  wire logic       clk_in,
	input  wire logic       slow_in,
	input  wire logic       req_in,
	input  wire logic       vec_valid_in,
	input  wire logic [8:0] vec_in,
	output logic            grant_out
);
	logic [8:0] vq[$];
	initial grant_out = 1'b0;
	// a slow host withholds grants so both channels can pend at once
	always @(posedge clk_in) begin
		if (vec_valid_in) begin
			vq.push_back(vec_in);
			grant_out <= 1'b0;
		end else if (req_in && !grant_out && !slow_in) begin
			grant_out <= 1'b1;
		end
	end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import sltx_pkg::*;
	logic clk_in = 1'b0, srst_in = 1'b1, init = 1'b0, sel = 1'b0, wr = 1'b0, rd = 1'b0;
	logic done = 1'b0, sser = 1'b0, line = 1'b0, ttick = 1'b0, rtick = 1'b0, rdone = 1'b0;
	logic rxen = 1'b0, mden = 1'b0, mclr = 1'b0, slow = 1'b0, grant, sout, rxs, rtk, lb, breq, vv;
	logic [15:0] wd = 16'h0, rdata;
	logic [7:0] sdata;
	logic [8:0] vec;
	logic [3:0] m = 4'h0;
	logic cen = 1'b1, ld, mchg;
	int bad_count = 0, total_checks = 0, loads = 0;
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) if (ld) loads++;
	sltx_ctrl u_dut (.clk_in(clk_in), .srst_in(srst_in), .clk_en_in(cen), .bus_init_in(init),
		.reg_sel_in(sel), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdata),
		.shift_load_out(ld), .shift_data_out(sdata), .shift_done_in(done), .shift_serial_in(sser),
		.serial_out(sout), .serial_line_in(line), .rx_serial_out(rxs), .tx_rate_tick_in(ttick),
		.rx_rate_tick_in(rtick), .rx_rate_tick_out(rtk), .loopback_test_out(lb),
		.rx_char_done_in(rdone), .rx_irq_enable_in(rxen), .modem_irq_enable_in(mden),
		.carrier_detect_in(m[0]), .cts_in(m[1]), .secondary_receive_in(m[2]), .ring_in(m[3]),
		.modem_change_clear_in(mclr), .modem_change_out(mchg), .bus_request_line_out(breq),
		.bus_request_level_out(), .bus_grant_in(grant), .bus_vector_valid_out(vv),
		.bus_vector_out(vec), .rx_irq_pending_out(), .tx_irq_pending_out());
	sltx_host u_host (.clk_in(clk_in), .slow_in(slow), .req_in(breq), .vec_valid_in(vv),
		.vec_in(vec), .grant_out(grant));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] a, input logic [15:0] e);
		total_checks++;
		if (a !== e) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, a, e);
		end
	endtask
	task automatic wr_reg(input logic s, input logic [15:0] d);
		sel = s;
		wd = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic s, input logic [15:0] e);
		sel = s;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		chk(rdata, e);
	endtask
	// the host logs every vector it fetched; a missing one ends the run
	task automatic wait_vec(input logic [8:0] e);
		int i;
		for (i = 0; i < 40 && u_host.vq.size() == 0; i++) cyc(1);
		if (i == 40) begin
			bad_count++;
			close_out();
		end
		chk({7'h0, u_host.vq.pop_front()}, {7'h0, e});
	endtask
	task automatic no_vec();
		cyc(12);
		chk(16'(u_host.vq.size()), 16'h0);
	endtask
	// ----------------------------------------------------------------
	// sequence of tests
	// ----------------------------------------------------------------
	initial begin
		cyc(6);
		srst_in = 1'b0;
		rd_reg(1'b0, 16'h0080);
		rd_reg(1'b1, 16'h0000);
		$display("test reset done");
		wr_reg(1'b0, 16'hffff);
		rd_reg(1'b0, 16'h00c5);
		sser = 1'b1;
		ttick = 1'b1;
		cyc(0);
		chk({lb, sout, rxs, rtk}, 16'h000b);
		no_vec();
		init = 1'b1;
		cyc(1);
		init = 1'b0;
		rd_reg(1'b0, 16'h0080);
		cen = 1'b0;
		wr_reg(1'b0, 16'h0005);
		cen = 1'b1;
		chk({lb, sout, rxs, rtk}, 16'h0004);
		$display("test control done");
		wr_reg(1'b0, 16'h0040);
		wr_reg(1'b1, 16'hab5a);
		rd_reg(1'b0, 16'h0040);
		wait_vec(DEF_CONSOLE_VECTOR + 9'h004);
		chk(16'(sdata), 16'h005a);
		wr_reg(1'b1, 16'h0033);
		cyc(5);
		rd_reg(1'b0, 16'h0040);
		no_vec();
		done = 1'b1;
		cyc(1);
		done = 1'b0;
		wait_vec(DEF_CONSOLE_VECTOR + 9'h004);
		chk(16'(sdata), 16'h0033);
		chk(16'(loads), 16'h0002);
		$display("test transmit done");
		slow = 1'b1;
		rxen = 1'b1;
		wr_reg(1'b1, 16'h0011);
		rdone = 1'b1;
		done = 1'b1;
		cyc(1);
		done = 1'b0;
		cyc(3);
		slow = 1'b0;
		wait_vec(DEF_CONSOLE_VECTOR);
		wait_vec(DEF_CONSOLE_VECTOR + 9'h004);
		rdone = 1'b0;
		rxen = 1'b0;
		cyc(2);
		rdone = 1'b1;
		no_vec();
		rdone = 1'b0;
		wr_reg(1'b0, 16'h0000);
		$display("test priority done");
		mden = 1'b1;
		for (int i = 0; i < 4; i++) begin
			m[i] = 1'b1;
			wait_vec(DEF_CONSOLE_VECTOR);
			chk(16'(mchg), 16'h0001);
			mclr = 1'b1;
			cyc(1);
			mclr = 1'b0;
		end
		mden = 1'b0;
		m = 4'h0;
		no_vec();
		$display("test modem done");
		close_out();
	end
	initial begin
		#100000;
		bad_count++;
		close_out();
	end
endmodule
